/* hdl/exu_pkg.sv */
// Purpose: shared constants and types of the cpu exception unit
// Assumes: 32-bit apb register port, one clock
// Notes: vector numbers here are neutral defaults, arbitrary values
package exu_pkg;
  // ****************************************
  // source counts
  // ****************************************
  localparam int NUM_IRQ = 8;
  localparam int NUM_XFER_ENG = 4;
  localparam int NUM_MFT = 24;
  localparam int NUM_SER = 8;
  localparam int NUM_ADC = 1;
  localparam int NUM_XFER_CTL = 1;
  localparam int NUM_CMT = 2;
  localparam int NUM_WDG = 1;
  localparam int NUM_BUS = 1;
  localparam int NUM_PORT = 1;
  localparam int NUM_PER = NUM_XFER_ENG + NUM_MFT + NUM_SER + NUM_ADC + NUM_XFER_CTL
                           + NUM_CMT + NUM_WDG + NUM_BUS + NUM_PORT;
  localparam int NUM_MSK = NUM_IRQ + NUM_PER;
  localparam int SRC_W = 6;
  localparam logic [SRC_W-1:0] SRC_UBRK = 6'h33;
  localparam logic [SRC_W-1:0] SRC_NMI = 6'h34;
  // ****************************************
  // levels and mask field
  // ****************************************
  localparam int LVL_W = 4;
  localparam logic [LVL_W:0] LVL_NMI = 5'h10;
  localparam logic [LVL_W:0] LVL_UBRK = 5'h0F;
  localparam logic [LVL_W-1:0] MASK_NMI = 4'hF;
  localparam int MASK_LSB = 4;
  // ****************************************
  // vectors, arbitrary neutral numbers
  // ****************************************
  localparam int VEC_W = 8;
  localparam int VEC_SHIFT = 2;
  localparam logic [VEC_W-1:0] VEC_GILL = 8'h04;
  localparam logic [VEC_W-1:0] VEC_SLOT = 8'h06;
  localparam logic [VEC_W-1:0] VEC_NMI = 8'h0B;
  localparam logic [VEC_W-1:0] VEC_UBRK = 8'h0C;
  localparam logic [VEC_W-1:0] VEC_IRQ0 = 8'h40;
  localparam logic [VEC_W-1:0] VEC_PER0 = 8'h48;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0002;
  // ****************************************
  // register map and reset values
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_VBASE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SP = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATE = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_PRIO0 = 12'h010;
  localparam int PRIO_WORDS = 7;
  localparam int PRIO_PER_WORD = 8;
  localparam logic [31:0] SR_RST = 32'h0000_00F0;
  localparam logic [31:0] VBR_RST = 32'h0000_0000;
  localparam logic [31:0] SP_RST = 32'h0000_0000;
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH_SR, ST_PUSH_PC, ST_FETCH} exu_state_type;
endpackage

/* hdl/exu_core.sv */
// Purpose: interrupt arbitration and exception entry sequence of the cpu
// Assumes: decoder stalls while exc_busy is high; memory port holds ack one cycle
// Notes: apb slave answers one cycle after the access phase starts

// Behaviour
// - requests come from nmi pin, user break, eight irq lines, peripherals
// - peripherals give 4, 24, 8, 2 and single sources per the table
// - each source owns a distinct vector number and table entry
// - levels run 0 lowest to 16 highest
// - nmi is level 16, never masked, accepted at any decode outside a slot without an instruction exception
// - user break sits at fixed level 15
// - irq and peripheral levels are programmable 0 to 15 only
// - simultaneous requests are resolved and the winner is processed
// - maskable request accepted only when level exceeds the mask field
// - acceptance pushes the status word, then the program counter
// - after stacking the accepted level goes into the mask field
// - nmi writes fifteen into the mask field
// - handler address is fetched from the vector entry, then jumped to
// - trap pushes status word then the address after the trap
// - trap vector comes from the number in the trap instruction
// - handler jump is immediate, no delay slot executed
// - undefined code in a delay slot raises illegal slot at decode
// - pc rewriting code in a delay slot also raises illegal slot
// - illegal slot pushes status word, then the delayed branch target
// - undefined code outside a slot raises general illegal, same sequence
// - general illegal pushes the address of the undefined code
// - vector entry address is vector base plus four times vector
// - no interrupt is accepted while decoding a delay slot
module exu_core
  import exu_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_pin,
  input wire logic [NUM_IRQ-1:0] irq_pin,
  input wire logic ubrk_req,
  input wire logic [NUM_PER-1:0] per_req,
  input wire logic dec_valid,
  input wire logic dec_undef,
  input wire logic dec_pc_write,
  input wire logic dec_trap,
  input wire logic [VEC_W-1:0] dec_trap_vec,
  input wire logic dec_in_slot,
  input wire logic [31:0] dec_pc,
  input wire logic [31:0] dec_branch_target,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic exc_busy,
  output logic jump_valid,
  output logic [31:0] jump_addr,
  output logic int_ack,
  output logic [SRC_W-1:0] int_ack_src,
  output logic [31:0] status_word
);
  // ****************************************
  // state
  // ****************************************
  exu_state_type state_r;
  logic nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_pend_r;
  logic [NUM_IRQ-1:0] irq_s1_r, irq_s2_r;
  logic [LVL_W-1:0] prio_r [NUM_MSK];
  logic [31:0] sr_r, vbr_r, sp_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic mem_req_r, mem_we_r;
  logic [31:0] mem_addr_r, mem_wdata_r;
  logic [31:0] push_pc_r, jump_addr_r;
  logic [VEC_W-1:0] vec_r;
  logic [LVL_W-1:0] new_mask_r;
  logic mask_load_r, jump_valid_r, int_ack_r;
  logic [SRC_W-1:0] int_src_r;
  logic [NUM_MSK-1:0] req_all;
  logic [LVL_W:0] best_lvl;
  logic [VEC_W-1:0] best_vec;
  logic [SRC_W-1:0] best_src;
  logic int_take, slot_exc, gill_exc, trap_exc, insn_exc, take_slot;
  logic [LVL_W-1:0] cur_mask;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  // irq and nmi come from pins; break and peripheral requests are on this clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_s3_r <= 1'b0;
      irq_s1_r <= '0;
      irq_s2_r <= '0;
    end else begin
      nmi_s1_r <= nmi_pin;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
      irq_s1_r <= irq_pin;
      irq_s2_r <= irq_s1_r;
    end
  end

  // nmi is an edge; latched so a short pulse survives a slot decode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_s2_r && !nmi_s3_r) begin
      nmi_pend_r <= 1'b1; // set wins over clear
    end else if (int_ack_r && int_src_r == SRC_NMI) begin
      nmi_pend_r <= 1'b0;
    end
  end

  // ****************************************
  // arbiter
  // ****************************************
  assign req_all = {per_req, irq_s2_r}; // two request classes, irq lines below peripheral requests
  assign cur_mask = sr_r[MASK_LSB +: LVL_W];

  always_comb begin
    best_lvl = '0;
    best_vec = '0;
    best_src = '0;
    // descending scan with >= lets the lowest index win a tie
    for (int i = NUM_MSK - 1; i >= 0; i--) begin
      if (req_all[i] && {1'b0, prio_r[i]} >= best_lvl && prio_r[i] != '0) begin
        best_lvl = {1'b0, prio_r[i]}; // programmable levels
        best_src = SRC_W'(i);
        // distinct vector per source
        best_vec = (i < NUM_IRQ) ? VEC_W'(VEC_IRQ0 + VEC_W'(i)) : VEC_W'(VEC_PER0 + VEC_W'(i - NUM_IRQ));
      end
    end
    if (ubrk_req && LVL_UBRK >= best_lvl) begin
      best_lvl = LVL_UBRK; // fixed break level
      best_src = SRC_UBRK;
      best_vec = VEC_UBRK;
    end
    if (nmi_pend_r) begin
      best_lvl = LVL_NMI; // top level, ignores the mask
      best_src = SRC_NMI;
      best_vec = VEC_NMI;
    end
  end

  // strict compare against mask; level 0 can never pass
  assign int_take = nmi_pend_r || (best_lvl > {1'b0, cur_mask});

  // ****************************************
  // instruction exceptions
  // ****************************************
  assign slot_exc = dec_in_slot && (dec_undef || dec_pc_write || dec_trap);
  assign gill_exc = !dec_in_slot && dec_undef;
  assign trap_exc = !dec_in_slot && !dec_undef && dec_trap;
  assign insn_exc = slot_exc || gill_exc || trap_exc;
  // slot decode never takes interrupts; they stay pending until the next decode
  assign take_slot = dec_valid && state_r == ST_IDLE;

  // ****************************************
  // entry capture
  // ****************************************
  // instruction exceptions win over interrupts at the same decode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      push_pc_r <= '0;
      vec_r <= '0;
      new_mask_r <= '0;
      mask_load_r <= 1'b0;
      int_ack_r <= 1'b0;
      int_src_r <= '0;
    end else begin
      int_ack_r <= 1'b0;
      if (take_slot && insn_exc) begin
        mask_load_r <= 1'b0;
        if (slot_exc) begin
          push_pc_r <= dec_branch_target;
          vec_r <= VEC_SLOT;
        end else if (gill_exc) begin
          push_pc_r <= dec_pc;
          vec_r <= VEC_GILL;
        end else begin
          push_pc_r <= dec_pc + INSN_BYTES;
          vec_r <= dec_trap_vec;
        end
      end else if (take_slot && !dec_in_slot && int_take) begin
        push_pc_r <= dec_pc;
        vec_r <= best_vec;
        mask_load_r <= 1'b1;
        // nmi level does not fit the field, fifteen is stored
        new_mask_r <= (best_src == SRC_NMI) ? MASK_NMI : best_lvl[LVL_W-1:0];
        int_ack_r <= 1'b1; // lets the source drop its held request
        int_src_r <= best_src;
      end
    end
  end

  // ****************************************
  // stacking and vector fetch
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= '0;
      jump_valid_r <= 1'b0;
      jump_addr_r <= '0;
    end else begin
      jump_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take_slot && (insn_exc || (!dec_in_slot && int_take))) begin
            state_r <= ST_PUSH_SR; // status word goes first
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b1;
            mem_addr_r <= sp_r - STACK_STEP;
            mem_wdata_r <= sr_r;
          end
        end
        ST_PUSH_SR: begin
          if (mem_ack) begin
            state_r <= ST_PUSH_PC;
            mem_addr_r <= sp_r - STACK_STEP - STACK_STEP;
            mem_wdata_r <= push_pc_r;
          end
        end
        ST_PUSH_PC: begin
          if (mem_ack) begin
            state_r <= ST_FETCH;
            mem_we_r <= 1'b0;
            mem_addr_r <= vbr_r + (32'(vec_r) << VEC_SHIFT);
            mem_wdata_r <= '0;
          end
        end
        ST_FETCH: begin
          if (mem_ack) begin
            state_r <= ST_IDLE;
            mem_req_r <= 1'b0;
            // direct load of the handler address, no slot follows
            jump_valid_r <= 1'b1;
            jump_addr_r <= mem_rdata;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          mem_req_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // apb slave and registers
  // ****************************************
  logic apb_go, prio_sel;
  logic [ADDR_W-1:0] prio_ofs;
  logic [ADDR_W-3:0] prio_word;
  assign apb_go = psel && penable && !pready_r;
  assign prio_ofs = paddr - OFS_PRIO0;
  assign prio_word = prio_ofs[ADDR_W-1:2];
  assign prio_sel = paddr >= OFS_PRIO0 && prio_word < (ADDR_W-2)'(PRIO_WORDS) && paddr[1:0] == 2'h0;

  // hardware updates of sp and mask win over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr_r <= SR_RST;
      vbr_r <= VBR_RST;
      sp_r <= SP_RST;
    end else begin
      if (apb_go && pwrite && reg_hit(paddr, OFS_STATUS)) begin
        sr_r <= pwdata;
      end
      if (apb_go && pwrite && reg_hit(paddr, OFS_VBASE)) begin
        vbr_r <= pwdata;
      end
      if (state_r == ST_PUSH_PC && mem_ack && mask_load_r) begin
        sr_r[MASK_LSB +: LVL_W] <= new_mask_r; // loaded only after stacking
      end
      if ((state_r == ST_PUSH_SR || state_r == ST_PUSH_PC) && mem_ack) begin
        sp_r <= sp_r - STACK_STEP;
      end else if (apb_go && pwrite && reg_hit(paddr, OFS_SP)) begin
        sp_r <= pwdata;
      end
    end
  end

  // eight levels per word; nibbles past the last source are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_MSK; i++) begin
        prio_r[i] <= '0;
      end
    end else if (apb_go && pwrite && prio_sel) begin
      for (int i = 0; i < NUM_MSK; i++) begin
        if (prio_word == (ADDR_W-2)'(i / PRIO_PER_WORD)) begin
          prio_r[i] <= pwdata[(i % PRIO_PER_WORD) * LVL_W +: LVL_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= apb_go;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      if (apb_go) begin
        if (reg_hit(paddr, OFS_STATUS)) begin
          prdata_r <= sr_r;
        end else if (reg_hit(paddr, OFS_VBASE)) begin
          prdata_r <= vbr_r;
        end else if (reg_hit(paddr, OFS_SP)) begin
          prdata_r <= sp_r;
        end else if (reg_hit(paddr, OFS_STATE)) begin
          prdata_r <= {15'h0000, nmi_pend_r, 2'h0, int_src_r, 7'h00, state_r != ST_IDLE};
        end else if (prio_sel) begin
          for (int i = 0; i < NUM_MSK; i++) begin
            if (prio_word == (ADDR_W-2)'(i / PRIO_PER_WORD)) begin
              prdata_r[(i % PRIO_PER_WORD) * LVL_W +: LVL_W] <= prio_r[i];
            end
          end
        end else begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign exc_busy = mem_req_r;
  assign jump_valid = jump_valid_r;
  assign jump_addr = jump_addr_r;
  assign int_ack = int_ack_r;
  assign int_ack_src = int_src_r;
  assign status_word = sr_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_sr_acked;
    state_r == ST_PUSH_SR && mem_ack;
  endsequence
  sequence s_pc_write;
    state_r == ST_PUSH_PC && mem_we_r && mem_wdata_r == push_pc_r;
  endsequence

  property p_ack_cause;
    int_ack_r |-> $past(take_slot && !dec_in_slot && !insn_exc && int_take);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without qualified request");

  property p_slot_hold;
    (take_slot && dec_in_slot) |=> !int_ack_r;
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("interrupt taken in delay slot");

  property p_push_order;
    s_sr_acked |=> s_pc_write;
  endproperty
  a_push_order: assert property (p_push_order) else $error("pc not pushed after status word");

  property p_mask_load;
    (state_r == ST_PUSH_PC && mem_ack && mask_load_r) |=> sr_r[MASK_LSB +: LVL_W] == $past(new_mask_r);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask field not loaded");

  property p_nmi_mask;
    (int_ack_r && int_src_r == SRC_NMI) |-> new_mask_r == MASK_NMI && vec_r == VEC_NMI;
  endproperty
  a_nmi_mask: assert property (p_nmi_mask) else $error("nmi mask value wrong");

  property p_vec_addr;
    (state_r == ST_FETCH && mem_req_r) |-> !mem_we_r && mem_addr_r == vbr_r + (32'(vec_r) << VEC_SHIFT);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector entry address wrong");

  property p_jump;
    (state_r == ST_FETCH && mem_ack) |=> jump_valid_r && jump_addr_r == $past(mem_rdata) ##1 !jump_valid_r;
  endproperty
  a_jump: assert property (p_jump) else $error("handler jump missing");

  property p_trap_pc;
    (take_slot && trap_exc) |=> push_pc_r == $past(dec_pc) + INSN_BYTES && vec_r == $past(dec_trap_vec);
  endproperty
  a_trap_pc: assert property (p_trap_pc) else $error("trap stack value wrong");

  property p_slot_pc;
    (take_slot && slot_exc) |=> push_pc_r == $past(dec_branch_target) && vec_r == VEC_SLOT ##1 state_r == ST_PUSH_SR;
  endproperty
  a_slot_pc: assert property (p_slot_pc) else $error("illegal slot entry wrong");

  property p_gill_pc;
    (take_slot && gill_exc) |=> push_pc_r == $past(dec_pc) && vec_r == VEC_GILL && !mask_load_r;
  endproperty
  a_gill_pc: assert property (p_gill_pc) else $error("general illegal entry wrong");

  property p_nmi_always;
    (take_slot && !dec_in_slot && !insn_exc && nmi_pend_r) |=> int_ack_r && int_src_r == SRC_NMI;
  endproperty
  a_nmi_always: assert property (p_nmi_always) else $error("nmi not accepted");
endmodule

/* dv/exu_mem_model.sv */
// Purpose: memory partner for the exception stacking and vector reads
// Assumes: one request held until ack, ack is a one-cycle pulse
// Notes: read data is a pattern of the address; data is inverted while idle, on write acks and after each ack
module exu_mem_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] lat,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // slave with selectable wait states
  // ********************************
  logic [1:0] cnt_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5A5A_5A5A;
    end else if (!mem_req || mem_ack) begin
      // restart the wait after every ack so a held request is not acked twice
      cnt_r <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (cnt_r == lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_we ? ~mem_rdata : mem_addr ^ 32'hA5A5_0000;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

/* dv/tb_cpu_interrupt_and_trap_exceptions.sv */
// Purpose: self-checking bench of the exception unit
// Assumes: apb master tasks, decoder stimulus, memory partner model
// Notes: source requests except irq line 2 are held until acknowledged, then dropped
module tb_cpu_interrupt_and_trap_exceptions;
  import exu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // signals and instances
  // ********************************
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, dec_pc = '0, mem_addr, mem_wdata, mem_rdata, jump_addr, status_word;
  logic nmi_pin = 0, ubrk_req = 0, dec_valid = 0, dec_undef = 0, dec_pc_write = 0, dec_trap = 0;
  logic dec_in_slot = 0, mem_req, mem_we, mem_ack, exc_busy, jump_valid, int_ack, ack_seen, rerr;
  logic [NUM_IRQ-1:0] irq_pin = '0;
  logic [NUM_PER-1:0] per_req = '0;
  logic [VEC_W-1:0] dec_trap_vec = '0;
  logic [SRC_W-1:0] int_ack_src, ack_src;
  logic [1:0] lat = 2'h0;
  logic [31:0] rdat, sp, vb, sr;
  logic [31:0] la[$];
  logic [31:0] ld[$];
  localparam logic [31:0] BT = 32'h0000_0500;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #20 clk = ~clk;
  exu_core uut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin), .irq_pin(irq_pin),
    .ubrk_req(ubrk_req), .per_req(per_req), .dec_valid(dec_valid), .dec_undef(dec_undef),
    .dec_pc_write(dec_pc_write), .dec_trap(dec_trap), .dec_trap_vec(dec_trap_vec), .dec_in_slot(dec_in_slot),
    .dec_pc(dec_pc), .dec_branch_target(BT), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .exc_busy(exc_busy),
    .jump_valid(jump_valid), .jump_addr(jump_addr), .int_ack(int_ack), .int_ack_src(int_ack_src),
    .status_word(status_word));
  exu_mem_model mem (.clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ********************************
  // monitor, checks and bus tasks
  // ********************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
    if (mem_req && mem_ack) begin
      la.push_back(mem_addr);
      ld.push_back(mem_we ? mem_wdata : mem_rdata);
    end
    if (int_ack) begin
      ack_seen = 1;
      ack_src = int_ack_src;
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("pslverr", 0, rerr);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rdat);
  endtask
  // kind 0: no entry expected, 1: instruction exception, 2: interrupt
  task automatic exc(input logic [3:0] cls, input logic [31:0] pc, input logic [VEC_W-1:0] tv,
    input logic [31:0] ppc, input logic [VEC_W-1:0] vec, input logic [SRC_W-1:0] src, input int kind,
    input logic [3:0] lvl);
    int n;
    la.delete();
    ld.delete();
    ack_seen = 0;
    {dec_in_slot, dec_undef, dec_pc_write, dec_trap} <= cls;
    dec_pc <= pc;
    dec_trap_vec <= tv;
    dec_valid <= 1'b1;
    @(posedge clk);
    dec_valid <= 1'b0;
    n = 0;
    while (kind != 0 && n < 60 && jump_valid !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    if (kind == 0) repeat (8) @(posedge clk);
    chk("accesses", kind != 0 ? 3 : 0, la.size());
    chk("jump_valid", kind != 0, jump_valid);
    chk("exc_busy", 0, exc_busy);
    chk("int_ack", kind == 2, ack_seen);
    if (kind != 0 && la.size() == 3) begin
      chk("sr_addr", sp - 4, la[0]);
      chk("sr_data", sr, ld[0]);
      chk("pc_addr", sp - 8, la[1]);
      chk("pc_data", ppc, ld[1]);
      chk("vec_addr", vb + {vec, 2'b00}, la[2]);
      chk("jump_addr", (vb + {vec, 2'b00}) ^ 32'hA5A5_0000, jump_addr);
      sp = sp - 8;
    end
    if (kind == 2) begin
      chk("src", src, ack_src);
      sr = {24'h0, lvl, 4'h0};
      chk("status", sr, status_word);
    end
  endtask
  // ********************************
  // tests
  // ********************************
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_STATUS, SR_RST);
    rd(OFS_VBASE, VBR_RST);
    apb(1'b0, 12'hFF0, 32'h0);
    chk("unmapped", 1, rerr);
    vb = 32'h0000_1000;
    sp = 32'h0000_2000;
    sr = SR_RST;
    wr(OFS_VBASE, vb);
    wr(OFS_SP, sp);
    wr(OFS_PRIO0, 32'h0000_F665);
    wr(OFS_PRIO0 + 12'h004, 32'h0000_000F);
    rd(OFS_PRIO0, 32'h0000_F665);
    $display("test registers done");
    exc(4'b0001, 32'h100, 8'h20, 32'h102, 8'h20, 6'h00, 1, 4'h0);
    lat <= 2'h3;
    exc(4'b1010, 32'h200, 8'h00, BT, VEC_SLOT, 6'h00, 1, 4'h0);
    exc(4'b1100, 32'h204, 8'h00, BT, VEC_SLOT, 6'h00, 1, 4'h0);
    exc(4'b1001, 32'h208, 8'h21, BT, VEC_SLOT, 6'h00, 1, 4'h0);
    exc(4'b0100, 32'h300, 8'h00, 32'h300, VEC_GILL, 6'h00, 1, 4'h0);
    $display("test instruction exceptions done");
    irq_pin <= 8'h01;
    wr(OFS_STATUS, 32'h0000_0050);
    sr = 32'h0000_0050;
    exc(4'b0000, 32'h400, 8'h00, 32'h400, VEC_IRQ0, 6'h00, 0, 4'h0);
    wr(OFS_STATUS, 32'h0000_0040);
    sr = 32'h0000_0040;
    exc(4'b1000, 32'h402, 8'h00, 32'h402, VEC_IRQ0, 6'h00, 0, 4'h0);
    exc(4'b0000, 32'h404, 8'h00, 32'h404, VEC_IRQ0, 6'h00, 2, 4'h5);
    irq_pin <= 8'h06;
    wr(OFS_STATUS, 32'h0);
    sr = 32'h0;
    exc(4'b0000, 32'h410, 8'h00, 32'h410, VEC_IRQ0 + 8'h01, 6'h01, 2, 4'h6);
    irq_pin <= 8'h00;
    ubrk_req <= 1'b1;
    per_req <= 43'h1;
    wr(OFS_STATUS, 32'h0);
    sr = 32'h0;
    exc(4'b0000, 32'h420, 8'h00, 32'h420, VEC_UBRK, SRC_UBRK, 2, 4'hF);
    ubrk_req <= 1'b0;
    exc(4'b0000, 32'h430, 8'h00, 32'h430, VEC_PER0, 6'h08, 0, 4'h0);
    wr(OFS_STATUS, 32'h0);
    sr = 32'h0;
    exc(4'b0000, 32'h440, 8'h00, 32'h440, VEC_PER0, 6'h08, 2, 4'hF);
    per_req <= 43'h0;
    nmi_pin <= 1'b1;
    repeat (4) @(posedge clk);
    exc(4'b0000, 32'h450, 8'h00, 32'h450, VEC_NMI, SRC_NMI, 2, MASK_NMI);
    nmi_pin <= 1'b0;
    rd(OFS_SP, sp);
    rd(OFS_STATE, {18'h0, SRC_NMI, 8'h00});
    $display("test interrupts done");
    end_sim();
  end
endmodule
